// ===== rtl/sec_pkg.sv
`default_nettype none

package sec_pkg;

	// Entry field layout, bit positions inside the stream table entry.
	localparam int HW_UPDATE_ACCESS_BIT   = 183;
	localparam int HW_UPDATE_DIRTY_BIT    = 184;
	localparam int FAULT_STALL_BIT        = 185;
	localparam int FAULT_RECORD_BIT       = 186;
	localparam int TABLE_BASE_FIELD_LSB   = 196;
	localparam int TABLE_BASE_FIELD_MSB   = 243;

	// Table base: the field holds address bits 51 down to 4.
	localparam int TABLE_BASE_ADDR_W      = 52;
	localparam int TABLE_BASE_FIELD_W     = 48;
	localparam int TABLE_BASE_ADDR_LSB    = 4;
	localparam int MIN_ALIGN_LOG2_52      = 6;

	// Output size codes and the address widths they stand for.
	localparam logic [2:0] OUT_SIZE_32    = 3'h0;
	localparam logic [2:0] OUT_SIZE_36    = 3'h1;
	localparam logic [2:0] OUT_SIZE_40    = 3'h2;
	localparam logic [2:0] OUT_SIZE_42    = 3'h3;
	localparam logic [2:0] OUT_SIZE_44    = 3'h4;
	localparam logic [2:0] OUT_SIZE_48    = 3'h5;
	localparam logic [2:0] OUT_SIZE_52    = 3'h6;
	localparam logic [5:0] PA_BITS_32     = 6'h20;
	localparam logic [5:0] PA_BITS_36     = 6'h24;
	localparam logic [5:0] PA_BITS_40     = 6'h28;
	localparam logic [5:0] PA_BITS_42     = 6'h2a;
	localparam logic [5:0] PA_BITS_44     = 6'h2c;
	localparam logic [5:0] PA_BITS_48     = 6'h30;
	localparam logic [5:0] PA_BITS_52     = 6'h34;
	localparam logic [5:0] PA_BITS_NARROW = 6'h28;

	// Granule codes.
	localparam logic [1:0] GRANULE_4K     = 2'h0;
	localparam logic [1:0] GRANULE_64K    = 2'h1;
	localparam logic [1:0] GRANULE_16K    = 2'h2;

	// Hardware update support capability codes.
	localparam logic [1:0] HW_UPD_NONE    = 2'h0;
	localparam logic [1:0] HW_UPD_ACCESS  = 2'h1;

	// Walk cacheability code for non-cacheable memory.
	localparam logic [1:0] WALK_NONCACHE  = 2'h0;

	// Register map, byte addresses on the plain register port.
	localparam logic [7:0] REG_STATUS     = 8'h00;
	localparam logic [7:0] REG_MASK       = 8'h04;
	localparam logic [7:0] REG_BAD_COUNT  = 8'h08;
	localparam int         STS_BAD_ENTRY  = 0;
	localparam int         STS_NC_UPDATE  = 1;
	localparam int         STS_W          = 2;
	localparam logic [1:0] STATUS_RESET   = 2'h0;
	localparam logic [1:0] MASK_RESET     = 2'h0;

endpackage

`default_nettype wire

// ===== rtl/sec_base_align.sv
`default_nettype none

module sec_base_align (
	input  wire logic [47:0] base_field_i,
	input  wire logic [5:0]  align_log2_i,
	input  wire logic [5:0]  pa_bits_i,
	output logic      [51:0] base_o,
	output logic             out_of_range_o
);

	function automatic logic [51:0] low_mask(input logic [5:0] n);
		logic [51:0] m;
		m = '0;
		for (int i = 0; i < 52; i++) begin
			if (i < int'(n)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	logic [51:0] raw_base;

	// Bits above 51 and below 4 are zero by construction.
	assign raw_base = {base_field_i, 4'h0};

	// Low bits under the table alignment are dropped before use.
	assign base_o = raw_base & ~low_mask(align_log2_i);

	// The unaligned value is checked so a stray high bit is never hidden.
	assign out_of_range_o = |(raw_base & ~low_mask(pa_bits_i));

endmodule

`default_nettype wire

// ===== rtl/sec_field_check.sv
`default_nettype none

module sec_field_check #(
	parameter bit EMBEDDED_IMPL = 1'b0,
	parameter bit NC_ATOMIC_OK  = 1'b0,
	parameter int ADDR_W        = 8,
	parameter int COUNT_W       = 16
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              entry_valid_i,
	input  wire logic              stage_two_enable_i,
	input  wire logic              second_stage_table_format_wide_i,
	input  wire logic              walk_access_flag_hw_update_i,
	input  wire logic              walk_dirty_state_hw_update_i,
	input  wire logic              fault_record_enable_i,
	input  wire logic              fault_stall_enable_i,
	input  wire logic [47:0]       second_stage_table_base_i,
	input  wire logic [1:0]        second_stage_granule_i,
	input  wire logic [2:0]        second_stage_output_size_i,
	input  wire logic [1:0]        walk_inner_cacheability_i,
	input  wire logic [1:0]        walk_outer_cacheability_i,
	input  wire logic              access_fault_disable_i,
	input  wire logic [5:0]        table_align_log2_i,
	input  wire logic              second_stage_present_i,
	input  wire logic [1:0]        hw_table_update_support_i,
	input  wire logic [2:0]        phys_addr_size_i,
	input  wire logic [ADDR_W-1:0] reg_addr_i,
	input  wire logic [31:0]       reg_wdata_i,
	input  wire logic              reg_we_i,
	input  wire logic              reg_re_i,
	output logic      [31:0]       reg_rdata_o,
	output logic                   irq_o,
	output logic                   result_valid_o,
	output logic                   entry_ok_o,
	output logic                   bad_entry_config_error_o,
	output logic                   access_update_o,
	output logic                   dirty_update_o,
	output logic                   fault_record_o,
	output logic                   fault_stall_o,
	output logic                   access_fault_disable_o,
	output logic      [51:0]       table_base_o
);

	if (ADDR_W < 4 || COUNT_W < 1 || COUNT_W > 32) begin : g_param_check
		$error("sec_field_check: ADDR_W must be 4 or more and COUNT_W 1 to 32");
	end

	function automatic logic [5:0] size_bits(input logic [2:0] code);
		case (code)
			sec_pkg::OUT_SIZE_32: size_bits = sec_pkg::PA_BITS_32;
			sec_pkg::OUT_SIZE_36: size_bits = sec_pkg::PA_BITS_36;
			sec_pkg::OUT_SIZE_40: size_bits = sec_pkg::PA_BITS_40;
			sec_pkg::OUT_SIZE_42: size_bits = sec_pkg::PA_BITS_42;
			sec_pkg::OUT_SIZE_44: size_bits = sec_pkg::PA_BITS_44;
			sec_pkg::OUT_SIZE_48: size_bits = sec_pkg::PA_BITS_48;
			default:              size_bits = sec_pkg::PA_BITS_52;
		endcase
	endfunction

	logic        stage_on;
	logic        acc_req;
	logic        dirty_req;
	logic        acc_bit;
	logic        dirty_bit;
	logic        ill_format;
	logic        ill_access;
	logic        ill_dirty;
	logic        ill_range;
	logic        illegal;
	logic        walk_nc;
	logic        nc_block;
	logic [5:0]  ps_bits;
	logic [5:0]  oas_bits;
	logic [5:0]  pa_eff;
	logic [5:0]  pa_range;
	logic        gran_64k;
	logic [5:0]  align_eff;
	logic [51:0] aligned_base;
	logic        out_of_range;

	// A stage that is not built has no enable to honour.
	assign stage_on = stage_two_enable_i & second_stage_present_i;

	// In an embedded build bits the support cannot serve read as zero, so they never offend.
	assign acc_req   = walk_access_flag_hw_update_i
	                 & ~(EMBEDDED_IMPL & (~second_stage_present_i
	                 | (hw_table_update_support_i == sec_pkg::HW_UPD_NONE)));
	assign dirty_req = walk_dirty_state_hw_update_i
	                 & ~(EMBEDDED_IMPL & (~second_stage_present_i
	                 | ~hw_table_update_support_i[1]));

	// Dirty tracking only counts together with access tracking.
	assign acc_bit   = acc_req;
	assign dirty_bit = acc_req & dirty_req;

	assign ill_format = stage_on & ~second_stage_table_format_wide_i & (acc_req | dirty_req);
	assign ill_access = stage_on & acc_req
	                  & (hw_table_update_support_i == sec_pkg::HW_UPD_NONE);
	assign ill_dirty  = stage_on & dirty_req & ~hw_table_update_support_i[1];

	assign ps_bits  = size_bits(second_stage_output_size_i);
	assign oas_bits = size_bits(phys_addr_size_i);
	assign gran_64k = second_stage_table_format_wide_i
	                & (second_stage_granule_i == sec_pkg::GRANULE_64K);
	assign pa_eff   = ~second_stage_table_format_wide_i ? sec_pkg::PA_BITS_NARROW
	                : ((ps_bits < oas_bits) ? ps_bits : oas_bits);
	// A 52-bit base is only reachable with the 64KB granule.
	assign pa_range = (~gran_64k && pa_eff > sec_pkg::PA_BITS_48) ? sec_pkg::PA_BITS_48
	                : pa_eff;

	assign align_eff = (gran_64k && pa_eff == sec_pkg::PA_BITS_52
	                 && table_align_log2_i < 6'(sec_pkg::MIN_ALIGN_LOG2_52))
	                 ? 6'(sec_pkg::MIN_ALIGN_LOG2_52) : table_align_log2_i;

	sec_base_align u_base_align (
		.base_field_i   (second_stage_table_base_i),
		.align_log2_i   (align_eff),
		.pa_bits_i      (pa_range),
		.base_o         (aligned_base),
		.out_of_range_o (out_of_range)
	);

	assign ill_range = stage_on & out_of_range;
	assign illegal   = ill_format | ill_access | ill_dirty | ill_range;

	// Atomic updates are only trusted on cacheable walks unless the build says otherwise.
	assign walk_nc  = (walk_inner_cacheability_i == sec_pkg::WALK_NONCACHE)
	                | (walk_outer_cacheability_i == sec_pkg::WALK_NONCACHE);
	assign nc_block = stage_on & acc_bit & walk_nc & ~NC_ATOMIC_OK;

	// Every check resolves in the same cycle as the entry, so results carry one edge of latency.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			result_valid_o           <= 1'b0;
			entry_ok_o               <= 1'b0;
			bad_entry_config_error_o <= 1'b0;
		end else begin
			result_valid_o           <= entry_valid_i;
			entry_ok_o               <= entry_valid_i & ~illegal;
			bad_entry_config_error_o <= entry_valid_i & illegal;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			access_update_o        <= 1'b0;
			dirty_update_o         <= 1'b0;
			fault_record_o         <= 1'b0;
			fault_stall_o          <= 1'b0;
			access_fault_disable_o <= 1'b0;
			table_base_o           <= '0;
		end else if (entry_valid_i) begin
			if (illegal) begin
				access_update_o        <= 1'b0;
				dirty_update_o         <= 1'b0;
				fault_record_o         <= 1'b0;
				fault_stall_o          <= 1'b0;
				access_fault_disable_o <= 1'b0;
				table_base_o           <= '0;
			end else begin
				access_update_o        <= stage_on & acc_bit & ~nc_block;
				dirty_update_o         <= stage_on & dirty_bit & ~nc_block;
				fault_record_o         <= stage_on & fault_record_enable_i;
				fault_stall_o          <= stage_on & fault_stall_enable_i;
				access_fault_disable_o <= stage_on & access_fault_disable_i & ~acc_bit;
				table_base_o           <= stage_on ? aligned_base : '0;
			end
		end
	end

	logic [sec_pkg::STS_W-1:0] status_q;
	logic [sec_pkg::STS_W-1:0] status_d;
	logic [sec_pkg::STS_W-1:0] status_set;
	logic [sec_pkg::STS_W-1:0] status_clr;
	logic [sec_pkg::STS_W-1:0] mask_q;
	logic [COUNT_W-1:0]        bad_count_q;
	logic                      sel_status;
	logic                      sel_mask;
	logic                      sel_count;

	assign sel_status = reg_addr_i == ADDR_W'(sec_pkg::REG_STATUS);
	assign sel_mask   = reg_addr_i == ADDR_W'(sec_pkg::REG_MASK);
	assign sel_count  = reg_addr_i == ADDR_W'(sec_pkg::REG_BAD_COUNT);

	always_comb begin
		status_set = '0;
		status_set[sec_pkg::STS_BAD_ENTRY] = entry_valid_i & illegal;
		status_set[sec_pkg::STS_NC_UPDATE] = entry_valid_i & ~illegal & nc_block;
		status_clr = (reg_we_i && sel_status) ? reg_wdata_i[sec_pkg::STS_W-1:0] : '0;
		// A new event in the clearing cycle survives the write.
		status_d   = (status_q & ~status_clr) | status_set;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			status_q <= sec_pkg::STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			mask_q <= sec_pkg::MASK_RESET;
		end else if (reg_we_i && sel_mask) begin
			mask_q <= reg_wdata_i[sec_pkg::STS_W-1:0];
		end
	end

	// The count saturates rather than wrapping, so a flood never looks like silence.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bad_count_q <= '0;
		end else if (entry_valid_i && illegal && !(&bad_count_q)) begin
			bad_count_q <= bad_count_q + COUNT_W'(1);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_d & mask_q);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_re_i && sel_status) begin
			reg_rdata_o <= 32'(status_q);
		end else if (reg_re_i && sel_mask) begin
			reg_rdata_o <= 32'(mask_q);
		end else if (reg_re_i && sel_count) begin
			reg_rdata_o <= 32'(bad_count_q);
		end else begin
			reg_rdata_o <= '0;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_access_decode;
		result_valid_o && entry_ok_o && $past(stage_on) && !$past(walk_nc) && !EMBEDDED_IMPL
			|-> access_update_o == $past(walk_access_flag_hw_update_i);
	endproperty
	a_access_decode: assert property (p_access_decode) else $error("access update decode wrong");

	property p_dirty_needs_access;
		result_valid_o |-> !(dirty_update_o && !access_update_o);
	endproperty
	a_dirty_needs_access: assert property (p_dirty_needs_access) else $error("dirty without access");

	property p_narrow_format_illegal;
		entry_valid_i && stage_on && !second_stage_table_format_wide_i && !EMBEDDED_IMPL
			&& (walk_access_flag_hw_update_i || walk_dirty_state_hw_update_i)
			|=> result_valid_o && !entry_ok_o;
	endproperty
	a_narrow_format_illegal: assert property (p_narrow_format_illegal) else $error("narrow update ok");

	property p_access_unsupported;
		entry_valid_i && stage_on && walk_access_flag_hw_update_i && !EMBEDDED_IMPL
			&& hw_table_update_support_i == sec_pkg::HW_UPD_NONE |=> bad_entry_config_error_o;
	endproperty
	a_access_unsupported: assert property (p_access_unsupported) else $error("access unsupported ok");

	property p_dirty_unsupported;
		entry_valid_i && stage_on && walk_dirty_state_hw_update_i && !EMBEDDED_IMPL
			&& !hw_table_update_support_i[1] |=> bad_entry_config_error_o && !entry_ok_o;
	endproperty
	a_dirty_unsupported: assert property (p_dirty_unsupported) else $error("dirty unsupported ok");

	property p_fault_ctrl_ignored;
		result_valid_o && !$past(stage_on) |-> !fault_record_o && !fault_stall_o;
	endproperty
	a_fault_ctrl_ignored: assert property (p_fault_ctrl_ignored) else $error("fault ctrl leaked");

	property p_base_low_zero;
		result_valid_o |-> table_base_o[3:0] == 4'h0;
	endproperty
	a_base_low_zero: assert property (p_base_low_zero) else $error("base low bits set");

	property p_base_52_align;
		entry_valid_i && stage_on && gran_64k && pa_eff == sec_pkg::PA_BITS_52
			|=> table_base_o[5:0] == 6'h00;
	endproperty
	a_base_52_align: assert property (p_base_52_align) else $error("52-bit base misaligned");

	property p_narrow_range;
		result_valid_o && entry_ok_o && !$past(second_stage_table_format_wide_i)
			|-> table_base_o[51:40] == 12'h000;
	endproperty
	a_narrow_range: assert property (p_narrow_range) else $error("base beyond narrow range");

	property p_afd_ignored;
		access_fault_disable_o |-> !access_update_o;
	endproperty
	a_afd_ignored: assert property (p_afd_ignored) else $error("fault disable with access update");

	property p_bad_sets_status;
		bad_entry_config_error_o |-> status_q[sec_pkg::STS_BAD_ENTRY];
	endproperty
	a_bad_sets_status: assert property (p_bad_sets_status) else $error("bad entry not flagged");

	property p_illegal_no_fields;
		result_valid_o && !entry_ok_o |-> table_base_o == '0 && !access_update_o
			&& !fault_record_o && !fault_stall_o;
	endproperty
	a_illegal_no_fields: assert property (p_illegal_no_fields) else $error("illegal fields used");

	property p_irq_follows_status;
		!(reg_we_i && sel_status) && |(status_q & mask_q) |=> irq_o;
	endproperty
	a_irq_follows_status: assert property (p_irq_follows_status) else $error("interrupt level wrong");

	c_bad_entry: cover property (bad_entry_config_error_o);
	c_full_update: cover property (result_valid_o && entry_ok_o && dirty_update_o);
	c_stall_fault: cover property (result_valid_o && fault_record_o && fault_stall_o);
	c_irq_raise: cover property (!irq_o ##1 irq_o);

endmodule

`default_nettype wire

// ===== tb/sec_tb_pkg.sv
`default_nettype none

package sec_tb_pkg;

	// One fetched entry: the raw entry bits plus the fields and capabilities beside them.
	typedef struct packed {
		logic [255:0] raw;
		logic         s2en;
		logic         wide;
		logic         afd;
		logic         present;
		logic [1:0]   gran;
		logic [1:0]   inner;
		logic [1:0]   outer;
		logic [1:0]   sup;
		logic [2:0]   osz;
		logic [2:0]   psz;
		logic [5:0]   align;
	} sec_ent_t;

	typedef struct packed {
		logic        ok;
		logic        bad;
		logic        a;
		logic        d;
		logic        rec;
		logic        stl;
		logic        afd;
		logic        nc;
		logic [51:0] base;
	} sec_exp_t;

endpackage

`default_nettype wire

// ===== tb/sec_entry_model.sv
`default_nettype none

module sec_entry_model (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 fetch_i,
	input  wire sec_tb_pkg::sec_ent_t ent_i,
	output var  logic                 entry_valid_o,
	output var  sec_tb_pkg::sec_ent_t ent_o
);
	timeunit 1ns;
	timeprecision 1ps;

	sec_tb_pkg::sec_ent_t ent_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			entry_valid_o <= 1'b0;
		end else begin
			entry_valid_o <= fetch_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (fetch_i) begin
			ent_q <= ent_i;
			if (!ent_i.present) begin
				ent_q.raw[sec_pkg::HW_UPDATE_ACCESS_BIT] <= 1'b0;
				ent_q.raw[sec_pkg::HW_UPDATE_DIRTY_BIT]  <= 1'b0;
			end
		end
	end

	// Between fetches the entry bits are inverted, so a stale entry is never reused unseen.
	always_comb begin
		ent_o = ent_q;
		if (!entry_valid_o) begin
			ent_o.raw = ~ent_q.raw;
		end
	end
endmodule

`default_nettype wire

// ===== tb/tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 mclk_i, rst_n_i, fetch, m_ev, rwe, rre, irq, rv, ok, bad;
	logic                 au, du, fr, fs, afd, ok2, au2, du2;
	sec_tb_pkg::sec_ent_t ent, m_e, e, g;
	logic [7:0]           radr;
	logic [31:0]          rwd, rdata, rd;
	logic [51:0]          base;
	logic [1:0]           exp_sts;
	logic [15:0]          exp_cnt;
	int                   errors, checks_done;
	int                   cycles = 0;

	sec_entry_model u_src (
		.mclk_i        (mclk_i),
		.rst_n_i       (rst_n_i),
		.fetch_i       (fetch),
		.ent_i         (ent),
		.entry_valid_o (m_ev),
		.ent_o         (m_e)
	);

	sec_field_check dut (
		.mclk_i (mclk_i), .rst_n_i (rst_n_i), .entry_valid_i (m_ev),
		.stage_two_enable_i (m_e.s2en), .second_stage_table_format_wide_i (m_e.wide),
		.walk_access_flag_hw_update_i (m_e.raw[sec_pkg::HW_UPDATE_ACCESS_BIT]),
		.walk_dirty_state_hw_update_i (m_e.raw[sec_pkg::HW_UPDATE_DIRTY_BIT]),
		.fault_record_enable_i (m_e.raw[sec_pkg::FAULT_RECORD_BIT]),
		.fault_stall_enable_i (m_e.raw[sec_pkg::FAULT_STALL_BIT]),
		.second_stage_table_base_i
			(m_e.raw[sec_pkg::TABLE_BASE_FIELD_MSB:sec_pkg::TABLE_BASE_FIELD_LSB]),
		.second_stage_granule_i (m_e.gran), .second_stage_output_size_i (m_e.osz),
		.walk_inner_cacheability_i (m_e.inner), .walk_outer_cacheability_i (m_e.outer),
		.access_fault_disable_i (m_e.afd), .table_align_log2_i (m_e.align),
		.second_stage_present_i (m_e.present), .hw_table_update_support_i (m_e.sup),
		.phys_addr_size_i (m_e.psz), .reg_addr_i (radr), .reg_wdata_i (rwd),
		.reg_we_i (rwe), .reg_re_i (rre), .reg_rdata_o (rdata), .irq_o (irq),
		.result_valid_o (rv), .entry_ok_o (ok), .bad_entry_config_error_o (bad),
		.access_update_o (au), .dirty_update_o (du), .fault_record_o (fr),
		.fault_stall_o (fs), .access_fault_disable_o (afd), .table_base_o (base)
	);

	// Second build with both options on: read-as-zero update bits and updates on any walk memory.
	sec_field_check #(.EMBEDDED_IMPL (1'b1), .NC_ATOMIC_OK (1'b1)) dut_ei (
		.mclk_i (mclk_i), .rst_n_i (rst_n_i), .entry_valid_i (m_ev),
		.stage_two_enable_i (m_e.s2en), .second_stage_table_format_wide_i (m_e.wide),
		.walk_access_flag_hw_update_i (m_e.raw[sec_pkg::HW_UPDATE_ACCESS_BIT]),
		.walk_dirty_state_hw_update_i (m_e.raw[sec_pkg::HW_UPDATE_DIRTY_BIT]),
		.fault_record_enable_i (m_e.raw[sec_pkg::FAULT_RECORD_BIT]),
		.fault_stall_enable_i (m_e.raw[sec_pkg::FAULT_STALL_BIT]),
		.second_stage_table_base_i
			(m_e.raw[sec_pkg::TABLE_BASE_FIELD_MSB:sec_pkg::TABLE_BASE_FIELD_LSB]),
		.second_stage_granule_i (m_e.gran), .second_stage_output_size_i (m_e.osz),
		.walk_inner_cacheability_i (m_e.inner), .walk_outer_cacheability_i (m_e.outer),
		.access_fault_disable_i (m_e.afd), .table_align_log2_i (m_e.align),
		.second_stage_present_i (m_e.present), .hw_table_update_support_i (m_e.sup),
		.phys_addr_size_i (m_e.psz), .reg_addr_i (radr), .reg_wdata_i (rwd),
		.reg_we_i (rwe), .reg_re_i (rre), .reg_rdata_o (), .irq_o (),
		.result_valid_o (), .entry_ok_o (ok2), .bad_entry_config_error_o (),
		.access_update_o (au2), .dirty_update_o (du2), .fault_record_o (),
		.fault_stall_o (), .access_fault_disable_o (), .table_base_o ()
	);

	function automatic logic [5:0] pa_of(input logic [2:0] c);
		case (c)
			sec_pkg::OUT_SIZE_32: pa_of = sec_pkg::PA_BITS_32;
			sec_pkg::OUT_SIZE_36: pa_of = sec_pkg::PA_BITS_36;
			sec_pkg::OUT_SIZE_40: pa_of = sec_pkg::PA_BITS_40;
			sec_pkg::OUT_SIZE_42: pa_of = sec_pkg::PA_BITS_42;
			sec_pkg::OUT_SIZE_44: pa_of = sec_pkg::PA_BITS_44;
			sec_pkg::OUT_SIZE_48: pa_of = sec_pkg::PA_BITS_48;
			default: pa_of = sec_pkg::PA_BITS_52;
		endcase
	endfunction

	function automatic sec_tb_pkg::sec_exp_t exp_of(input sec_tb_pkg::sec_ent_t n);
		sec_tb_pkg::sec_exp_t x;
		logic a, d, on, nc;
		logic [5:0] pa, al;
		logic [51:0] ad;
		x = '0;
		a = n.raw[sec_pkg::HW_UPDATE_ACCESS_BIT];
		d = n.raw[sec_pkg::HW_UPDATE_DIRTY_BIT];
		ad = {n.raw[sec_pkg::TABLE_BASE_FIELD_MSB:sec_pkg::TABLE_BASE_FIELD_LSB], 4'h0};
		on = n.s2en & n.present;
		pa = (pa_of(n.osz) < pa_of(n.psz)) ? pa_of(n.osz) : pa_of(n.psz);
		if (n.gran != sec_pkg::GRANULE_64K && pa > sec_pkg::PA_BITS_48) pa = sec_pkg::PA_BITS_48;
		if (!n.wide) pa = sec_pkg::PA_BITS_NARROW;
		al = n.align;
		if (n.gran == sec_pkg::GRANULE_64K && pa == sec_pkg::PA_BITS_52 && al < 6'h06) al = 6'h06;
		x.bad = on & (((a | d) & !n.wide) | (a & (n.sup == sec_pkg::HW_UPD_NONE))
			| (d & (n.sup <= sec_pkg::HW_UPD_ACCESS)) | ((ad >> pa) != 52'h0));
		x.ok = !x.bad;
		if (on && !x.bad) begin
			nc = (n.inner == sec_pkg::WALK_NONCACHE) || (n.outer == sec_pkg::WALK_NONCACHE);
			x.nc = nc & a;
			x.a = a & !nc;
			x.d = a & d & !nc;
			x.rec = n.raw[sec_pkg::FAULT_RECORD_BIT];
			x.stl = n.raw[sec_pkg::FAULT_STALL_BIT];
			x.afd = n.afd & !a;
			x.base = (ad >> al) << al;
		end
		return x;
	endfunction

	function automatic sec_tb_pkg::sec_ent_t mk(input logic a, input logic d, input logic r,
			input logic s, input logic [47:0] f);
		sec_tb_pkg::sec_ent_t x;
		x = '0;
		x.raw[sec_pkg::HW_UPDATE_ACCESS_BIT] = a;
		x.raw[sec_pkg::HW_UPDATE_DIRTY_BIT] = d;
		x.raw[sec_pkg::FAULT_RECORD_BIT] = r;
		x.raw[sec_pkg::FAULT_STALL_BIT] = s;
		x.raw[sec_pkg::TABLE_BASE_FIELD_MSB:sec_pkg::TABLE_BASE_FIELD_LSB] = f;
		x.s2en = 1'b1;
		x.wide = 1'b1;
		x.present = 1'b1;
		x.sup = 2'h2;
		x.osz = sec_pkg::OUT_SIZE_48;
		x.psz = sec_pkg::OUT_SIZE_52;
		x.align = 6'h0c;
		x.inner = 2'h1;
		x.outer = 2'h1;
		return x;
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] want);
		checks_done++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: seen %h wanted %h", $time, seen, want);
		end
	endtask

	task automatic check_entry(input sec_tb_pkg::sec_ent_t n);
		sec_tb_pkg::sec_exp_t x;
		x = exp_of(n);
		chk(rv, 1'b1);
		chk(ok, x.ok);
		chk(bad, x.bad);
		chk(au, x.a);
		chk(du, x.d);
		chk(fr, x.rec);
		chk(fs, x.stl);
		chk(afd, x.afd);
		chk(base, x.base);
		exp_sts = exp_sts | {x.nc, x.bad};
		if (x.bad && exp_cnt != 16'hffff) exp_cnt = exp_cnt + 16'h1;
	endtask

	// With two set, the second entry follows the first with no idle cycle.
	task automatic send(input sec_tb_pkg::sec_ent_t a, input sec_tb_pkg::sec_ent_t b,
			input logic two);
		@(posedge mclk_i);
		fetch <= 1'b1;
		ent <= a;
		@(posedge mclk_i);
		if (two) ent <= b;
		else fetch <= 1'b0;
		@(posedge mclk_i);
		fetch <= 1'b0;
		#1;
		check_entry(a);
		if (two) begin
			@(posedge mclk_i);
			#1;
			check_entry(b);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		rwe <= 1'b1;
		radr <= a;
		rwd <= d;
		@(posedge mclk_i);
		rwe <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] want);
		@(posedge mclk_i);
		rre <= 1'b1;
		radr <= a;
		@(posedge mclk_i);
		rre <= 1'b0;
		#1;
		chk(rdata, want);
	endtask

	task automatic irq_is(input logic v);
		repeat (2) @(posedge mclk_i);
		#1;
		chk(irq, v);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		fetch = 1'b0;
		ent = '0;
		radr = 8'h00;
		rwd = 32'h0;
		rwe = 1'b0;
		rre = 1'b0;
		errors = 0;
		checks_done = 0;
		exp_sts = 2'h0;
		exp_cnt = 16'h0;
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		#1;
		chk(rv, 1'b0);
		reg_read(sec_pkg::REG_STATUS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			e = mk(i[0], i[1], 1'b0, 1'b0, 48'h0000_0000_1230);
			send(e, e, 1'b0);
			e = mk(1'b0, 1'b0, i[1], i[0], 48'h0000_0000_1230);
			send(e, e, 1'b0);
			e.s2en = 1'b0;
			send(e, e, 1'b0);
		end
		e = mk(1'b1, 1'b0, 1'b0, 1'b0, 48'h0000_0000_1230);
		e.wide = 1'b0;
		send(e, e, 1'b0);
		e.wide = 1'b1;
		e.sup = sec_pkg::HW_UPD_NONE;
		send(e, e, 1'b0);
		chk(ok2, 1'b1);
		chk(au2, 1'b0);
		e = mk(1'b1, 1'b1, 1'b0, 1'b0, 48'h0000_0000_1230);
		e.sup = sec_pkg::HW_UPD_ACCESS;
		g = mk(1'b0, 1'b1, 1'b0, 1'b0, 48'h0000_0000_1230);
		g.sup = sec_pkg::HW_UPD_ACCESS;
		send(e, g, 1'b1);
		e = mk(1'b1, 1'b1, 1'b1, 1'b1, 48'h0000_0000_1230);
		e.present = 1'b0;
		send(e, e, 1'b0);
		e = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h0000_0fff_ffff);
		send(e, e, 1'b0);
		e = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h8000_0000_0003);
		e.gran = sec_pkg::GRANULE_64K;
		e.osz = sec_pkg::OUT_SIZE_52;
		e.align = 6'h04;
		send(e, e, 1'b0);
		e.psz = sec_pkg::OUT_SIZE_48;
		send(e, e, 1'b0);
		e = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h0010_0000_0000);
		g = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h000f_ffff_ffff);
		send(e, g, 1'b1);
		e = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h0000_0fff_ffff);
		e.wide = 1'b0;
		g = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h0000_1000_0000);
		g.wide = 1'b0;
		send(e, g, 1'b1);
		e = mk(1'b1, 1'b0, 1'b0, 1'b0, 48'h0000_0000_1230);
		e.afd = 1'b1;
		g = mk(1'b0, 1'b0, 1'b0, 1'b0, 48'h0000_0000_1230);
		g.afd = 1'b1;
		send(e, g, 1'b1);
		e = mk(1'b1, 1'b1, 1'b0, 1'b0, 48'h0000_0000_1230);
		e.inner = sec_pkg::WALK_NONCACHE;
		e.outer = sec_pkg::WALK_NONCACHE;
		send(e, e, 1'b0);
		chk(au2, 1'b1);
		chk(du2, 1'b1);
		reg_read(sec_pkg::REG_STATUS, {30'h0, exp_sts});
		reg_read(sec_pkg::REG_BAD_COUNT, {16'h0, exp_cnt});
		reg_write(sec_pkg::REG_BAD_COUNT, 32'h0);
		reg_read(sec_pkg::REG_BAD_COUNT, {16'h0, exp_cnt});
		reg_read(8'h0c, 32'h0);
		irq_is(1'b0);
		reg_write(sec_pkg::REG_MASK, 32'h1);
		irq_is(1'b1);
		reg_read(sec_pkg::REG_MASK, 32'h1);
		reg_write(sec_pkg::REG_STATUS, 32'h1);
		irq_is(1'b0);
		reg_read(sec_pkg::REG_STATUS, 32'h2);
		reg_write(sec_pkg::REG_MASK, 32'h3);
		irq_is(1'b1);
		reg_write(sec_pkg::REG_STATUS, 32'h3);
		irq_is(1'b0);
		report_and_stop();
	end
endmodule

`default_nettype wire
